// [logic/debug_command_flash_unlock.sv]
`timescale 1ns/10ps
`include "debug_command_flash_unlock_defs.svh"

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  // fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // drain side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  wire              empty;
  wire              full;
  wire              push;
  wire              pop;

  // full and empty from pointers with a wrap bit
  assign empty         = (wr_ptr_q == rd_ptr_q);
  assign full          = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                         (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem_q[rd_ptr_q[AW-1:0]];
  assign push          = in_valid_in && !full;
  assign pop           = out_ready_in && !empty;

  // storage write
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data_in;
    end
  end

  // pointer update
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + (AW+1)'(push);
      rd_ptr_q <= rd_ptr_q + (AW+1)'(pop);
    end
  end
endmodule

module debug_command_flash_unlock (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // debug link receive bytes
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  output logic             rx_ready_out,
  // debug link transmit bytes
  output logic             tx_valid_out,
  output logic [7:0]       tx_data_out,
  input  wire logic        tx_ready_in,
  // cpu register file port
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [11:0] reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic [7:0]       reg_rdata_out,
  // device state
  input  wire logic        read_protect_in,
  input  wire logic [15:0] pc_in,
  input  wire logic [7:0]  page_select_in,
  // debug control and program counter
  output logic [7:0]       debug_control_reg_out,
  output logic             debug_halt_state_bit_out,
  output logic             pc_load_out,
  output logic [15:0]      pc_value_out,
  // debug register file writes
  output logic             dbg_reg_wr_out,
  output logic [11:0]      dbg_reg_addr_out,
  output logic [7:0]       dbg_reg_data_out,
  // flash controller actions
  output logic             page_erase_out,
  output logic [7:0]       erase_page_out,
  output logic             mass_erase_out,
  output logic             sector_protect_en_out,
  output logic [4:0]       trim_option_index_out
);
  debug_command_flash_unlock_pkg::handler_state_t state_q, state_d;
  debug_command_flash_unlock_pkg::flash_state_t   fstate_q, fstate_d;

  logic [7:0]  ctl_q;
  logic [7:0]  pc_hi_q;
  logic [11:0] addr_q;
  logic [8:0]  count_q;
  logic [7:0]  tx_q;
  logic [15:0] pc_cap_q;
  logic [4:0]  trim_q;
  logic        sector_q;
  logic [7:0]  rdata_q;
  logic        pc_load_q;
  logic [15:0] pc_val_q;
  logic        dwr_q;
  logic [11:0] daddr_q;
  logic [7:0]  ddata_q;
  logic        perase_q;
  logic [7:0]  epage_q;
  logic        merase_q;

  wire         fifo_valid;
  wire [7:0]   fifo_data;
  wire         take;
  wire         tx_go;
  wire         halted;
  wire         rx_state;
  wire         commit;
  wire [7:0]   ctl_new;
  wire         dbg_fc_wr;
  wire         cpu_fc_wr;
  wire         fc_wr;
  wire [7:0]   fc_data;
  wire         fc_from_dbg;
  wire         dbg_trim_wr;
  wire         cpu_trim_wr;
  wire [7:0]   flash_status;

  // true for addresses of the flash control register group
  function automatic logic is_flash_reg(input logic [11:0] a);
    return (a >= `ADDR_FLASH_REG_LO) && (a <= `ADDR_FLASH_REG_HI);
  endfunction

  // incoming link bytes pass through a buffer before the handler
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (`RX_FIFO_DEPTH)
  ) rx_fifo (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .in_valid_in   (rx_valid_in),
    .in_data_in    (rx_data_in),
    .in_ready_out  (rx_ready_out),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (rx_state)
  );

  // handshake and gating terms
  assign halted   = ctl_q[`DBG_CTL_HALT_BIT];
  assign rx_state = (state_q != debug_command_flash_unlock_pkg::ST_TX_CTL) &&
                    (state_q != debug_command_flash_unlock_pkg::ST_TX_PC_HI) &&
                    (state_q != debug_command_flash_unlock_pkg::ST_TX_PC_LO);
  assign take     = rx_state && fifo_valid;
  assign tx_valid_out = !rx_state;
  assign tx_go    = tx_valid_out && tx_ready_in;
  assign commit   = take && halted &&
                    (state_q == debug_command_flash_unlock_pkg::ST_WR_DATA) &&
                    (!read_protect_in || is_flash_reg(addr_q));
  // halt bit sticks under read protect
  assign ctl_new  = {fifo_data[7] | (read_protect_in & halted),
                     fifo_data[6:0]};

  // writes that reach flash command and trim index
  assign dbg_fc_wr   = commit && (addr_q == `ADDR_FLASH_COMMAND);
  assign cpu_fc_wr   = reg_wr_in && (reg_addr_in == `ADDR_FLASH_COMMAND);
  assign fc_wr       = dbg_fc_wr || cpu_fc_wr;
  assign fc_from_dbg = dbg_fc_wr;
  assign fc_data     = dbg_fc_wr ? fifo_data : reg_wdata_in;
  assign dbg_trim_wr = commit && (addr_q == `ADDR_TRIM_INDEX);
  assign cpu_trim_wr = reg_wr_in && (reg_addr_in == `ADDR_TRIM_INDEX);
  assign flash_status = {3'h0, sector_q, 2'h0, fstate_q};

  always_comb begin
    state_d = state_q;
    case (state_q)
      debug_command_flash_unlock_pkg::ST_IDLE: begin
        if (take) begin
          case (fifo_data)
            `DBG_CMD_WR_CTL:
              state_d = debug_command_flash_unlock_pkg::ST_CTL_DATA;
            `DBG_CMD_RD_CTL:
              state_d = debug_command_flash_unlock_pkg::ST_TX_CTL;
            `DBG_CMD_WR_PC:
              state_d = debug_command_flash_unlock_pkg::ST_PC_HI;
            `DBG_CMD_RD_PC:
              state_d = debug_command_flash_unlock_pkg::ST_TX_PC_HI;
            `DBG_CMD_WR_REG:
              state_d = debug_command_flash_unlock_pkg::ST_WR_ADDR_HI;
            default:
              state_d = debug_command_flash_unlock_pkg::ST_IDLE;
          endcase
        end
      end
      debug_command_flash_unlock_pkg::ST_CTL_DATA: begin
        if (take) state_d = debug_command_flash_unlock_pkg::ST_IDLE;
      end
      debug_command_flash_unlock_pkg::ST_PC_HI: begin
        if (take) state_d = debug_command_flash_unlock_pkg::ST_PC_LO;
      end
      debug_command_flash_unlock_pkg::ST_PC_LO: begin
        if (take) state_d = debug_command_flash_unlock_pkg::ST_IDLE;
      end
      debug_command_flash_unlock_pkg::ST_WR_ADDR_HI: begin
        if (take) state_d = debug_command_flash_unlock_pkg::ST_WR_ADDR_LO;
      end
      debug_command_flash_unlock_pkg::ST_WR_ADDR_LO: begin
        if (take) state_d = debug_command_flash_unlock_pkg::ST_WR_SIZE;
      end
      debug_command_flash_unlock_pkg::ST_WR_SIZE: begin
        if (take) state_d = debug_command_flash_unlock_pkg::ST_WR_DATA;
      end
      debug_command_flash_unlock_pkg::ST_WR_DATA: begin
        if (take && count_q == 9'h001) begin
          state_d = debug_command_flash_unlock_pkg::ST_IDLE;
        end
      end
      debug_command_flash_unlock_pkg::ST_TX_CTL: begin
        if (tx_go) state_d = debug_command_flash_unlock_pkg::ST_IDLE;
      end
      debug_command_flash_unlock_pkg::ST_TX_PC_HI: begin
        if (tx_go) state_d = debug_command_flash_unlock_pkg::ST_TX_PC_LO;
      end
      debug_command_flash_unlock_pkg::ST_TX_PC_LO: begin
        if (tx_go) state_d = debug_command_flash_unlock_pkg::ST_IDLE;
      end
      default: state_d = debug_command_flash_unlock_pkg::ST_IDLE;
    endcase
  end

  always_comb begin
    fstate_d = fstate_q;
    if (fc_wr) begin
      case (fstate_q)
        debug_command_flash_unlock_pkg::FL_LOCKED: begin
          if (fc_data == `FLASH_UNLOCK_FIRST) begin
            fstate_d = debug_command_flash_unlock_pkg::FL_FIRST_SEEN;
          end else begin
            fstate_d = debug_command_flash_unlock_pkg::FL_LOCKED;
          end
        end
        debug_command_flash_unlock_pkg::FL_FIRST_SEEN: begin
          if (fc_data == `FLASH_UNLOCK_SECOND) begin
            fstate_d = debug_command_flash_unlock_pkg::FL_UNLOCKED;
          end else begin
            fstate_d = debug_command_flash_unlock_pkg::FL_LOCKED;
          end
        end
        debug_command_flash_unlock_pkg::FL_UNLOCKED: begin
          // erase start or anything but 5EH relocks
          if (fc_data == `FLASH_SECTOR_ACCESS) begin
            fstate_d = debug_command_flash_unlock_pkg::FL_UNLOCKED;
          end else begin
            fstate_d = debug_command_flash_unlock_pkg::FL_LOCKED;
          end
        end
        default: fstate_d = debug_command_flash_unlock_pkg::FL_LOCKED;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q  <= debug_command_flash_unlock_pkg::ST_IDLE;
      fstate_q <= debug_command_flash_unlock_pkg::FL_LOCKED;
    end else begin
      state_q  <= state_d;
      fstate_q <= fstate_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctl_q <= `DBG_CTL_RESET;
    end else if (take &&
                 state_q == debug_command_flash_unlock_pkg::ST_CTL_DATA) begin
      ctl_q <= ctl_new;
    end
  end

  // program counter write, discarded unless allowed
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pc_hi_q   <= 8'h00;
      pc_load_q <= 1'b0;
      pc_val_q  <= 16'h0000;
    end else begin
      pc_load_q <= 1'b0;
      if (take && state_q == debug_command_flash_unlock_pkg::ST_PC_HI) begin
        pc_hi_q <= fifo_data;
      end
      if (take && state_q == debug_command_flash_unlock_pkg::ST_PC_LO &&
          halted && !read_protect_in) begin
        pc_load_q <= 1'b1;
        pc_val_q  <= {pc_hi_q, fifo_data};
      end
    end
  end

  // address and byte count of register writes
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      addr_q  <= 12'h000;
      count_q <= 9'h000;
    end else if (take) begin
      case (state_q)
        debug_command_flash_unlock_pkg::ST_WR_ADDR_HI:
          addr_q[11:8] <= fifo_data[3:0];
        debug_command_flash_unlock_pkg::ST_WR_ADDR_LO:
          addr_q[7:0] <= fifo_data;
        debug_command_flash_unlock_pkg::ST_WR_SIZE:
          count_q <= (fifo_data == 8'h00) ? `WR_REG_FULL_COUNT
                                          : {1'b0, fifo_data};
        debug_command_flash_unlock_pkg::ST_WR_DATA: begin
          addr_q  <= addr_q + 12'h001;
          count_q <= count_q - 9'h001;
        end
        default: addr_q <= addr_q;
      endcase
    end
  end

  // committed writes toward the register file
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      dwr_q   <= 1'b0;
      daddr_q <= 12'h000;
      ddata_q <= 8'h00;
    end else begin
      dwr_q <= commit;
      if (commit) begin
        daddr_q <= addr_q;
        ddata_q <= fifo_data;
      end
    end
  end

  // answer bytes, PC masked when not allowed
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_q     <= 8'h00;
      pc_cap_q <= 16'h0000;
    end else if (take &&
                 state_q == debug_command_flash_unlock_pkg::ST_IDLE) begin
      tx_q     <= (fifo_data == `DBG_CMD_RD_CTL) ? ctl_q :
                  ((halted && !read_protect_in) ? pc_in[15:8] : 8'hFF);
      pc_cap_q <= (halted && !read_protect_in) ? pc_in : 16'hFFFF;
    end else if (tx_go &&
                 state_q == debug_command_flash_unlock_pkg::ST_TX_PC_HI) begin
      tx_q <= pc_cap_q[7:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      perase_q <= 1'b0;
      epage_q  <= 8'h00;
      merase_q <= 1'b0;
      sector_q <= 1'b0;
    end else begin
      perase_q <= 1'b0;
      merase_q <= 1'b0;
      if (fc_wr) begin
        sector_q <= (fc_data == `FLASH_SECTOR_ACCESS);
      end
      if (fc_wr &&
          fstate_q == debug_command_flash_unlock_pkg::FL_UNLOCKED) begin
        if (fc_data == `FLASH_PAGE_ERASE) begin
          perase_q <= 1'b1;
          epage_q  <= page_select_in;
        end
        if (fc_data == `FLASH_MASS_ERASE && fc_from_dbg) begin
          merase_q <= 1'b1;
        end
      end
    end
  end

  // trim index, debug path wins a same-cycle clash
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      trim_q <= `TRIM_INDEX_RESET;
    end else if (dbg_trim_wr) begin
      trim_q <= fifo_data[`TRIM_INDEX_WIDTH-1:0];
    end else if (cpu_trim_wr) begin
      trim_q <= reg_wdata_in[`TRIM_INDEX_WIDTH-1:0];
    end
  end

  // cpu reads, command address shows status
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_in) begin
      if (reg_addr_in == `ADDR_TRIM_INDEX) begin
        rdata_q <= {3'h0, trim_q};
      end else if (reg_addr_in == `ADDR_FLASH_COMMAND) begin
        rdata_q <= flash_status;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // output drive
  assign tx_data_out              = tx_q;
  assign reg_rdata_out            = rdata_q;
  assign debug_control_reg_out    = ctl_q;
  assign debug_halt_state_bit_out = halted;
  assign pc_load_out              = pc_load_q;
  assign pc_value_out             = pc_val_q;
  assign dbg_reg_wr_out           = dwr_q;
  assign dbg_reg_addr_out         = daddr_q;
  assign dbg_reg_data_out         = ddata_q;
  // page select names one 512 byte page
  assign page_erase_out           = perase_q;
  assign erase_page_out           = epage_q;
  assign mass_erase_out           = merase_q;
  assign sector_protect_en_out    = sector_q;
  assign trim_option_index_out    = trim_q;
endmodule

// [logic/debug_command_flash_unlock_defs.svh]
`ifndef DEBUG_COMMAND_FLASH_UNLOCK_DEFS_SVH
`define DEBUG_COMMAND_FLASH_UNLOCK_DEFS_SVH

// debug command codes
`define DBG_CMD_WR_CTL      8'h04
`define DBG_CMD_RD_CTL      8'h05
`define DBG_CMD_WR_PC       8'h06
`define DBG_CMD_RD_PC       8'h07
`define DBG_CMD_WR_REG      8'h08

// debug control register
`define DBG_CTL_RESET       8'h00
`define DBG_CTL_HALT_BIT    7

// flash command codes
`define FLASH_UNLOCK_FIRST  8'h73
`define FLASH_UNLOCK_SECOND 8'h8C
`define FLASH_PAGE_ERASE    8'h95
`define FLASH_MASS_ERASE    8'h63
`define FLASH_SECTOR_ACCESS 8'h5E

// register file addresses
`define ADDR_TRIM_INDEX     12'hFF6
`define ADDR_FLASH_COMMAND  12'hFF8
`define ADDR_FLASH_REG_LO   12'hFF8
`define ADDR_FLASH_REG_HI   12'hFFF

// reset values and field layout
`define TRIM_INDEX_RESET    5'h00
`define TRIM_INDEX_WIDTH    5
`define FLASH_CMD_RESET     8'h00
`define STATUS_SECTOR_BIT   4

// transfer sizes
`define WR_REG_FULL_COUNT   9'h100
`define FLASH_PAGE_BYTES    512
`define RX_FIFO_DEPTH       32

`endif

// [logic/debug_command_flash_unlock_pkg.sv]
package debug_command_flash_unlock_pkg;

  // command handler states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CTL_DATA,
    ST_PC_HI,
    ST_PC_LO,
    ST_WR_ADDR_HI,
    ST_WR_ADDR_LO,
    ST_WR_SIZE,
    ST_WR_DATA,
    ST_TX_CTL,
    ST_TX_PC_HI,
    ST_TX_PC_LO
  } handler_state_t;

  // flash controller lock states
  typedef enum logic [1:0] {
    FL_LOCKED,
    FL_FIRST_SEEN,
    FL_UNLOCKED
  } flash_state_t;

endpackage

// [sim/debug_command_flash_unlock_assertions.sv]
`timescale 1ns/10ps
`include "debug_command_flash_unlock_defs.svh"

module debug_command_flash_unlock_assertions (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // link answers
  input  wire logic        tx_valid_out,
  input  wire logic [7:0]  tx_data_out,
  input  wire logic        tx_ready_in,
  // cpu register port
  input  wire logic        reg_rd_in,
  input  wire logic        reg_wr_in,
  input  wire logic [11:0] reg_addr_in,
  input  wire logic [7:0]  reg_rdata_out,
  // device state and results
  input  wire logic        read_protect_in,
  input  wire logic [7:0]  page_select_in,
  input  wire logic        debug_halt_state_bit_out,
  input  wire logic        pc_load_out,
  input  wire logic        dbg_reg_wr_out,
  input  wire logic [11:0] dbg_reg_addr_out,
  input  wire logic        page_erase_out,
  input  wire logic [7:0]  erase_page_out,
  input  wire logic        mass_erase_out,
  input  wire logic        sector_protect_en_out,
  input  wire logic [4:0]  trim_option_index_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // register reads and flash sequencing
  a_trim_readback: assert property (
    reg_rd_in && !reg_wr_in && reg_addr_in == `ADDR_TRIM_INDEX
    |=> reg_rdata_out == {3'h0, $past(trim_option_index_out)})
    else $error("trim index read back differs");
  a_status_read: assert property (
    reg_rd_in && reg_addr_in == `ADDR_FLASH_COMMAND
    |=> reg_rdata_out[7:5] == 3'h0 && reg_rdata_out[3:2] == 2'h0 &&
        reg_rdata_out[1:0] != 2'h3 &&
        reg_rdata_out[4] == $past(sector_protect_en_out))
    else $error("flash status read malformed");
  a_erase_page: assert property (
    page_erase_out |-> erase_page_out == $past(page_select_in))
    else $error("erase targets wrong page");
  a_erase_relock: assert property (
    page_erase_out || mass_erase_out
    |=> (!page_erase_out && !mass_erase_out) [*2])
    else $error("erase repeated without unlock");
  // debug command gating and answer byte hold
  a_pc_gate: assert property (
    pc_load_out |-> $past(debug_halt_state_bit_out) && !$past(read_protect_in))
    else $error("pc loaded while not allowed");
  a_halt_sticky: assert property (
    read_protect_in && debug_halt_state_bit_out |=> debug_halt_state_bit_out)
    else $error("halt bit cleared under protect");
  a_wr_needs_halt: assert property (
    dbg_reg_wr_out |-> $past(debug_halt_state_bit_out))
    else $error("register write outside debug mode");
  a_protect_regs: assert property (
    dbg_reg_wr_out && $past(read_protect_in)
    |-> dbg_reg_addr_out >= `ADDR_FLASH_REG_LO)
    else $error("protected write to non flash register");
  a_tx_stands: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("answer byte dropped before taken");

  // main scenarios reached
  c_page: cover property (page_erase_out);
  c_mass: cover property (mass_erase_out);
  c_pc: cover property (pc_load_out);
  c_prot: cover property (dbg_reg_wr_out && read_protect_in);
endmodule

bind debug_command_flash_unlock debug_command_flash_unlock_assertions chk_u (
  .*);

// [sim/link_host_model.sv]
`timescale 1ns/10ps

module link_host_model (
  // clock
  input  wire logic       clock_in,
  // bytes toward the block
  input  wire logic       rx_ready_in,
  output logic            rx_valid_out,
  output logic [7:0]      rx_data_out,
  // answers from the block
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out
);
  int gap_n;

  // idle link: nothing offered, no answer taken
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'hA5;
    tx_ready_out = 1'b0;
    gap_n = 0;
  end

  // offer one byte, hold it until taken, optionally idle between bytes
  task send(input logic [7:0] b, input logic last);
    logic ok;
    rx_valid_out = 1'b1;
    rx_data_out = b;
    ok = 1'b0;
    while (!ok) begin
      @(negedge clock_in);
      ok = rx_ready_in;
      @(posedge clock_in);
    end
    #1;
    if (last || gap_n > 0) begin
      rx_valid_out = 1'b0;
      rx_data_out = ~b; // released data never shows the stale byte
    end
    repeat (gap_n) @(posedge clock_in);
    if (gap_n > 0) #1;
  endtask

  // take one answer byte after an optional stall
  task recv(output logic [7:0] b, input int stall);
    logic ok;
    int n;
    repeat (stall) @(posedge clock_in);
    #1;
    tx_ready_out = 1'b1;
    ok = 1'b0;
    n = 0;
    while (!ok && n < 200) begin
      @(negedge clock_in);
      ok = tx_valid_in;
      b = tx_data_in;
      @(posedge clock_in);
      n++;
    end
    #1;
    tx_ready_out = 1'b0;
  endtask
endmodule

// [sim/debug_command_flash_unlock_tb_top.sv]
`timescale 1ns/10ps
`include "debug_command_flash_unlock_defs.svh"

module debug_command_flash_unlock_tb_top;
  // design ports
  logic        clock_in, rst_in, rx_valid_in, rx_ready_out, tx_valid_out;
  logic        tx_ready_in, reg_wr_in, reg_rd_in, read_protect_in;
  logic        debug_halt_state_bit_out, pc_load_out, dbg_reg_wr_out;
  logic        page_erase_out, mass_erase_out, sector_protect_en_out;
  logic [7:0]  rx_data_in, tx_data_out, reg_wdata_in, reg_rdata_out;
  logic [7:0]  page_select_in, debug_control_reg_out, erase_page_out;
  logic [7:0]  dbg_reg_data_out;
  logic [11:0] reg_addr_in, dbg_reg_addr_out;
  logic [15:0] pc_in, pc_value_out;
  logic [4:0]  trim_option_index_out;
  // bench state
  logic [7:0]  msg[$];
  logic [19:0] wr_q[$];
  logic [7:0]  pg_seen;
  logic [15:0] pc_seen;
  int          bad_count, n_tests, pe_n, me_n, pl_n, cyc;

  debug_command_flash_unlock dut_u (.*);

  link_host_model host_u (
    .clock_in(clock_in), .rx_ready_in(rx_ready_out),
    .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
    .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out),
    .tx_ready_out(tx_ready_in));

  // clock
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  // pulse monitors sample mid-cycle, away from the launching edge
  always @(negedge clock_in) begin
    if (page_erase_out) begin
      pe_n++;
      pg_seen = erase_page_out;
    end
    if (mass_erase_out) me_n++;
    if (pc_load_out) begin
      pl_n++;
      pc_seen = pc_value_out;
    end
    if (dbg_reg_wr_out) wr_q.push_back({dbg_reg_addr_out, dbg_reg_data_out});
  end

  // hang guard
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out;
    end
  end

  task check(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task do_reset;
    rst_in = 1'b1;
    repeat (5) @(posedge clock_in);
    #1;
    rst_in = 1'b0;
  endtask

  // one cpu register write or read, one strobe cycle each
  task cpu_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #1;
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(posedge clock_in);
    #1;
    reg_wr_in = 1'b0;
  endtask

  task rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(posedge clock_in);
    #1;
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(posedge clock_in);
    #1;
    reg_rd_in = 1'b0;
    check(reg_rdata_out, e);
  endtask

  // send the queued link bytes, then let the handler drain them
  task flush;
    foreach (msg[i]) host_u.send(msg[i], i == msg.size() - 1);
    msg.delete();
    repeat (40) @(posedge clock_in);
    #1;
  endtask

  task halt(input logic [7:0] c);
    msg = '{`DBG_CMD_WR_CTL, c};
    flush;
  endtask

  task get16(input int stall, output logic [15:0] v);
    host_u.recv(v[15:8], 0);
    host_u.recv(v[7:0], stall);
  endtask

  task t_regs;
    check(trim_option_index_out, 5'h00);
    rd_chk(`ADDR_TRIM_INDEX, 8'h00);
    rd_chk(`ADDR_FLASH_COMMAND, 8'h00);
    cpu_wr(`ADDR_TRIM_INDEX, 8'hFF);
    rd_chk(`ADDR_TRIM_INDEX, 8'h1F);
    cpu_wr(`ADDR_TRIM_INDEX, 8'h0A);
    check(trim_option_index_out, 5'h0A);
    rd_chk(12'h100, 8'h00);
    cpu_wr(`ADDR_FLASH_COMMAND, `FLASH_UNLOCK_FIRST);
    rd_chk(`ADDR_FLASH_COMMAND, 8'h01);
    $display("test registers done");
  endtask

  task t_ctl;
    logic [7:0] b;
    halt(8'h80);
    check(debug_control_reg_out, 8'h80);
    msg = '{`DBG_CMD_RD_CTL};
    flush;
    host_u.recv(b, 2);
    check(b, 8'h80);
    read_protect_in = 1'b1;
    halt(8'h01);
    check(debug_control_reg_out, 8'h81);
    check(debug_halt_state_bit_out, 1'b1);
    read_protect_in = 1'b0;
    do_reset;
    check(debug_control_reg_out, 8'h00);
    $display("test control done");
  endtask

  task t_pc;
    logic [15:0] v;
    halt(8'h80);
    pc_in = 16'h1234;
    msg = '{`DBG_CMD_RD_PC};
    flush;
    get16(3, v);
    check(v, 16'h1234);
    msg = '{`DBG_CMD_WR_PC, 8'hAB, 8'hCD};
    flush;
    check(pl_n, 1);
    check(pc_seen, 16'hABCD);
    read_protect_in = 1'b1;
    msg = '{`DBG_CMD_RD_PC};
    flush;
    get16(0, v);
    check(v, 16'hFFFF);
    msg = '{`DBG_CMD_WR_PC, 8'h11, 8'h22};
    flush;
    check(pl_n, 1);
    read_protect_in = 1'b0;
    halt(8'h00);
    msg = '{`DBG_CMD_RD_PC};
    flush;
    get16(0, v);
    check(v, 16'hFFFF);
    $display("test program counter done");
  endtask

  task t_regwr;
    halt(8'h80);
    wr_q.delete();
    host_u.gap_n = 2;
    msg = '{`DBG_CMD_WR_REG, 8'h01, 8'hFE, 8'h02, 8'hA5, 8'h5A};
    flush;
    host_u.gap_n = 0;
    check(wr_q.size(), 2);
    check(wr_q[0], {12'h1FE, 8'hA5});
    check(wr_q[1], {12'h1FF, 8'h5A});
    wr_q.delete();
    msg = '{`DBG_CMD_WR_REG, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 256; i++) msg.push_back(i[7:0]);
    flush;
    check(wr_q.size(), 256);
    check(wr_q[255], {12'h0FF, 8'hFF});
    wr_q.delete();
    read_protect_in = 1'b1;
    msg = '{`DBG_CMD_WR_REG, 8'h0F, 8'hF7, 8'h02, 8'h11, 8'h22};
    flush;
    check(wr_q.size(), 1);
    check(wr_q[0], {12'hFF8, 8'h22});
    read_protect_in = 1'b0;
    halt(8'h00);
    wr_q.delete();
    msg = '{`DBG_CMD_WR_REG, 8'h00, 8'h10, 8'h01, 8'h33};
    flush;
    check(wr_q.size(), 0);
    $display("test register write done");
  endtask

  task t_flash;
    page_select_in = 8'h05;
    cpu_wr(`ADDR_FLASH_COMMAND, `FLASH_UNLOCK_FIRST);
    cpu_wr(`ADDR_FLASH_COMMAND, `FLASH_UNLOCK_SECOND);
    rd_chk(`ADDR_FLASH_COMMAND, 8'h02);
    cpu_wr(`ADDR_FLASH_COMMAND, `FLASH_PAGE_ERASE);
    rd_chk(`ADDR_FLASH_COMMAND, 8'h00);
    check(pe_n, 1);
    check(pg_seen, 8'h05);
    cpu_wr(`ADDR_FLASH_COMMAND, `FLASH_PAGE_ERASE);
    rd_chk(`ADDR_FLASH_COMMAND, 8'h00);
    check(pe_n, 1);
    cpu_wr(`ADDR_FLASH_COMMAND, `FLASH_UNLOCK_FIRST);
    cpu_wr(`ADDR_FLASH_COMMAND, `FLASH_UNLOCK_SECOND);
    cpu_wr(`ADDR_FLASH_COMMAND, `FLASH_MASS_ERASE);
    rd_chk(`ADDR_FLASH_COMMAND, 8'h00);
    check(me_n, 0);
    cpu_wr(`ADDR_FLASH_COMMAND, `FLASH_SECTOR_ACCESS);
    rd_chk(`ADDR_FLASH_COMMAND, 8'h10);
    check(sector_protect_en_out, 1'b1);
    cpu_wr(`ADDR_FLASH_COMMAND, `FLASH_UNLOCK_FIRST);
    rd_chk(`ADDR_FLASH_COMMAND, 8'h01);
    cpu_wr(`ADDR_FLASH_COMMAND, 8'h00);
    rd_chk(`ADDR_FLASH_COMMAND, 8'h00);
    halt(8'h80);
    msg = '{`DBG_CMD_WR_REG, 8'h0F, 8'hF8, 8'h01, 8'h73,
            `DBG_CMD_WR_REG, 8'h0F, 8'hF8, 8'h01, 8'h8C,
            `DBG_CMD_WR_REG, 8'h0F, 8'hF8, 8'h01, 8'h63};
    flush;
    check(me_n, 1);
    $display("test flash commands done");
  endtask

  task t_fifo;
    logic [7:0] b;
    msg = '{`DBG_CMD_RD_CTL};
    flush;
    for (int i = 0; i < 40; i++) msg.push_back(8'h00);
    fork
      flush;
      begin
        repeat (60) @(posedge clock_in);
        #1;
        check(rx_ready_out, 1'b0);
        host_u.recv(b, 0);
        check(b, 8'h80);
      end
    join
    $display("test buffer full done");
  endtask

  // main sequence
  initial begin
    {reg_wr_in, reg_rd_in, read_protect_in} = 3'h0;
    reg_addr_in = 12'h000;
    reg_wdata_in = 8'h00;
    pc_in = 16'h0000;
    page_select_in = 8'h00;
    do_reset;
    t_regs;
    t_ctl;
    t_pc;
    t_regwr;
    t_flash;
    t_fifo;
    close_out;
  end
endmodule
